// ==== dif_top.sv ====
// Contact input function decoder with register port, ride-through and loopback test.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/100ps
// Function
// [RL1] Integral reset held while contact closed
// [RL2] Integral frozen while hold contact closed
// [RL3] Setpoint ramp bypassed while cancel closed
// [RL4] Error negated while polarity contact closed
// [RL5] Scheme one: forward, reverse, else stop
// [RL6] Scheme two: run contact, direction contact
// [RL7] Never assign both two-wire schemes together
// [RL8] Active offset inputs add their offsets
// [RL9] Brake input brakes a stopped motor
// [RL10] Run or jog releases brake, jog first
// [RL11] Search one starts from maximum frequency (code: only with CFG_METHOD clear, else from frequency reference)
// [RL12] Search two starts from frequency reference
// [RL13] Search contact triggers regardless of start setting
// [RL14] Both search functions raise setting conflict
// [RL15] Search waits out minimum block time
// [RL16] Ride-through bus target 1.35 times voltage
// [RL17] Ride-through decelerates, timeout gives undervoltage
// [RL18] Zero time limit reaccelerates at normal rate
// [RL19] Ride-through has closed and open variants
// [RL20] Voltage 155 to 255, doubled high class
// [RL21] Test mode sends data, checks echo
// [RL22] Operator loops transmit back to receive
// [RL23] Conflicting assignments raise setting conflict
// [RL24] Contacts sampled and decoded every cycle
module dif_top #(
  parameter int NUM_IN    = 7,
  parameter int TENTH_CYC = dif_pkg::TENTH_CYC
) (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic [NUM_IN-1:0] contact_in,
  input  wire logic        motor_stopped,
  input  wire logic        jog_cmd,
  input  wire logic        output_block,
  input  wire logic        power_loss,
  input  wire logic        ser_rx,
  output logic             ser_tx,
  output logic             integ_reset,
  output logic             integ_hold,
  output logic             ramp_cancel,
  output logic             err_invert,
  output logic             run_fwd,
  output logic             run_rev,
  output logic             jog_run,
  output logic      [17:0] offset_add,
  output logic             dc_brake,
  output logic             search_start,
  output logic             search_from_max,
  output logic             setting_conflict_error,
  output logic             ride_active,
  output logic             fast_decel,
  output logic      [13:0] bus_target,
  output logic             undervoltage_fault,
  output logic             reaccel_normal,
  output logic             test_busy,
  output logic             test_pass,
  output logic             test_fail
);
  // ==========================================================================
  // Input synchronisers
  logic [NUM_IN-1:0] cont_m_q, cont_q;
  logic              rx_m_q, rx_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      cont_m_q <= '0;
      cont_q   <= '0;
      rx_m_q   <= 1'b1;
      rx_q     <= 1'b1;
    end else begin
      cont_m_q <= contact_in;
      cont_q   <= cont_m_q;
      rx_m_q   <= ser_rx;
      rx_q     <= rx_m_q;
    end
  end
  // ==========================================================================
  // Registers
  logic [7:0]  fsel_q [NUM_IN];
  logic [15:0] ofs_q [3];
  logic [2:0]  cfg_q;
  logic [7:0]  minbb_q, rtlim_q;
  logic [8:0]  volt_q;
  logic [8:0]  vlo, vhi;
  assign vlo = cfg_q[dif_pkg::CFG_HICLASS] ? {dif_pkg::VOLT_LO[7:0], 1'b0} : dif_pkg::VOLT_LO;
  assign vhi = cfg_q[dif_pkg::CFG_HICLASS] ? {dif_pkg::VOLT_HI[7:0], 1'b0} : dif_pkg::VOLT_HI;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < NUM_IN; i++) fsel_q[i] <= dif_pkg::FSEL_RST;
      for (int i = 0; i < 3; i++) ofs_q[i] <= dif_pkg::OFS_RST;
      cfg_q   <= dif_pkg::CFG_RST;
      minbb_q <= dif_pkg::MINBB_RST;
      rtlim_q <= dif_pkg::RTLIM_RST;
      volt_q  <= dif_pkg::VOLT_DEF;
    end else if (reg_wr) begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (reg_addr == dif_pkg::A_FSEL0 + 8'(i)) fsel_q[i] <= reg_wdata[7:0];
      end
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == dif_pkg::A_OFS0 + 8'(i)) ofs_q[i] <= reg_wdata;
      end
      if (reg_addr == dif_pkg::A_CFG) begin
        cfg_q <= reg_wdata[2:0];
        // [RL20] class change reloads default
        if (reg_wdata[dif_pkg::CFG_HICLASS] != cfg_q[dif_pkg::CFG_HICLASS]) begin
          volt_q <= reg_wdata[dif_pkg::CFG_HICLASS] ? {dif_pkg::VOLT_DEF[7:0], 1'b0} : dif_pkg::VOLT_DEF;
        end
      end else if (reg_addr == dif_pkg::A_MINBB) begin
        minbb_q <= reg_wdata[7:0];
      end else if (reg_addr == dif_pkg::A_RTLIM) begin
        rtlim_q <= reg_wdata[7:0];
      end else if (reg_addr == dif_pkg::A_VOLT) begin
        // [RL20] out-of-range writes ignored
        if (reg_wdata[8:0] >= vlo && reg_wdata[8:0] <= vhi && reg_wdata[15:9] == 7'h00) begin
          volt_q <= reg_wdata[8:0];
        end
      end
    end
  end
  // ==========================================================================
  // Function decode
  logic c_irst, c_ihld, c_sfsc, c_einv, c_fwd1, c_rev1, c_run2, c_dir2;
  logic c_dcb, c_ss1, c_ss2, c_rt, c_ctst;
  logic [2:0] c_ofs;
  logic a_s1, a_s2, a_ss1, a_ss2;
  // [RL24] per-terminal decode
  always_comb begin
    {c_irst, c_ihld, c_sfsc, c_einv, c_fwd1, c_rev1, c_run2, c_dir2} = 8'h00;
    {c_dcb, c_ss1, c_ss2, c_rt, c_ctst} = 5'h00;
    c_ofs = 3'h0;
    {a_s1, a_s2, a_ss1, a_ss2} = 4'h0;
    for (int i = 0; i < NUM_IN; i++) begin
      case (fsel_q[i])
        dif_pkg::FN_IRST: c_irst |= cont_q[i];
        dif_pkg::FN_IHLD: c_ihld |= cont_q[i];
        dif_pkg::FN_SFSC: c_sfsc |= cont_q[i];
        dif_pkg::FN_EINV: c_einv |= cont_q[i];
        dif_pkg::FN_FWD1: begin c_fwd1 |= cont_q[i]; a_s1 = 1'b1; end
        dif_pkg::FN_REV1: begin c_rev1 |= cont_q[i]; a_s1 = 1'b1; end
        dif_pkg::FN_RUN2: begin c_run2 |= cont_q[i]; a_s2 = 1'b1; end
        dif_pkg::FN_DIR2: begin c_dir2 |= cont_q[i]; a_s2 = 1'b1; end
        dif_pkg::FN_OFS1: c_ofs[0] |= cont_q[i];
        dif_pkg::FN_OFS2: c_ofs[1] |= cont_q[i];
        dif_pkg::FN_OFS3: c_ofs[2] |= cont_q[i];
        dif_pkg::FN_DCB:  c_dcb |= cont_q[i];
        dif_pkg::FN_SS1:  begin c_ss1 |= cont_q[i]; a_ss1 = 1'b1; end
        dif_pkg::FN_SS2:  begin c_ss2 |= cont_q[i]; a_ss2 = 1'b1; end
        // [RL19] closed-active and open-active variants
        dif_pkg::FN_RTNC: c_rt |= ~cont_q[i];
        dif_pkg::FN_RTNO: c_rt |= cont_q[i];
        dif_pkg::FN_CTST: c_ctst |= cont_q[i];
        default: ;
      endcase
    end
  end
  // ==========================================================================
  // PID, run and offset levels
  logic run_any;
  assign run_any = (a_s1 & (c_fwd1 ^ c_rev1)) | (a_s2 & c_run2);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {integ_reset, integ_hold, ramp_cancel, err_invert} <= 4'h0;
      {run_fwd, run_rev, jog_run, dc_brake} <= 4'h0;
      offset_add <= '0;
      setting_conflict_error <= 1'b0;
    end else begin
      // [RL1] reset dominates hold
      integ_reset <= c_irst;
      // [RL2] freeze while closed
      integ_hold  <= c_ihld & ~c_irst;
      // [RL3] ramp bypass
      ramp_cancel <= c_sfsc;
      // [RL4] error inversion
      err_invert  <= c_einv;
      // [RL10] jog wins over run
      jog_run <= jog_cmd;
      // [RL5] [RL6] both closed in scheme one means stop
      run_fwd <= ~jog_cmd & ((a_s1 & c_fwd1 & ~c_rev1) | (a_s2 & c_run2 & c_dir2));
      run_rev <= ~jog_cmd & ((a_s1 & c_rev1 & ~c_fwd1) | (a_s2 & c_run2 & ~c_dir2));
      // [RL9] [RL10] brake only stopped, released by requests
      dc_brake <= c_dcb & motor_stopped & ~run_any & ~jog_cmd;
      // [RL8] offset sum
      offset_add <= (c_ofs[0] ? 18'(ofs_q[0]) : 18'h00000) + (c_ofs[1] ? 18'(ofs_q[1]) : 18'h00000)
                  + (c_ofs[2] ? 18'(ofs_q[2]) : 18'h00000);
      // [RL14] [RL23] [RL7] conflicting assignments flagged
      setting_conflict_error <= (a_ss1 & a_ss2) | (a_s1 & a_s2);
    end
  end
  // ==========================================================================
  // Shared tenth-second tick
  logic [$clog2(TENTH_CYC+1)-1:0] pre_q;
  logic tick;
  assign tick = (pre_q == '0);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) pre_q <= '0;
    else if (tick) pre_q <= ($clog2(TENTH_CYC+1))'(TENTH_CYC - 1);
    else pre_q <= pre_q - 1'b1;
  end
  // ==========================================================================
  // Speed search sequencing
  logic ss1_q, ss2_q, run_q, blk_q, pend_q, pmax_q;
  logic [8:0] bb_q;
  logic trig_ss1, trig_ss2, trig_start;
  assign trig_ss1   = c_ss1 & ~ss1_q;
  assign trig_ss2   = c_ss2 & ~ss2_q;
  assign trig_start = run_any & ~run_q & ~cfg_q[dif_pkg::CFG_NOSTART];
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      {ss1_q, ss2_q, run_q, blk_q, pend_q, pmax_q} <= 6'h00;
      bb_q <= '0;
      search_start <= 1'b0;
      search_from_max <= 1'b0;
    end else begin
      ss1_q <= c_ss1;
      ss2_q <= c_ss2;
      run_q <= run_any;
      blk_q <= output_block;
      search_start <= 1'b0;
      // [RL15] timer loads one extra tenth so the wait is never short
      if (output_block) bb_q <= {1'b0, minbb_q} + 9'h001;
      else if (tick && bb_q != '0) bb_q <= bb_q - 9'h001;
      // [RL13] contact edges trigger regardless of start setting
      if (trig_ss1 | trig_ss2 | trig_start) begin
        pend_q <= 1'b1;
        // [RL11] [RL12] start point by method and input
        pmax_q <= trig_ss1 & ~cfg_q[dif_pkg::CFG_METHOD];
      end else if (pend_q && !output_block && !blk_q && bb_q == '0) begin
        // [RL15] start only after block time
        pend_q <= 1'b0;
        search_start <= 1'b1;
        search_from_max <= pmax_q;
      end
    end
  end
  // ==========================================================================
  // Ride-through
  dif_pkg::dif_rt_e rt_q;
  logic [7:0] rt_cnt_q;
  logic [17:0] bus_prod;
  assign bus_prod = 18'(volt_q) * 18'(dif_pkg::BUS_NUM);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rt_q <= dif_pkg::DIF_RT_IDLE;
      rt_cnt_q <= '0;
      {ride_active, fast_decel, undervoltage_fault, reaccel_normal} <= 4'h0;
      bus_target <= '0;
    end else begin
      reaccel_normal <= 1'b0;
      // [RL16] target = 1.35 x voltage setting
      bus_target <= 14'(bus_prod / 18'(dif_pkg::BUS_DEN));
      case (rt_q)
        dif_pkg::DIF_RT_IDLE: begin
          if (c_rt && power_loss) begin
            rt_q <= dif_pkg::DIF_RT_RIDE;
            rt_cnt_q <= '0;
            ride_active <= 1'b1;
            fast_decel <= 1'b1;
          end
        end
        dif_pkg::DIF_RT_RIDE: begin
          if (tick && rt_cnt_q != 8'hFF) rt_cnt_q <= rt_cnt_q + 8'h01;
          if (!power_loss) begin
            rt_q <= dif_pkg::DIF_RT_IDLE;
            {ride_active, fast_decel} <= 2'b00;
            // [RL18] zero limit means reaccelerate at normal rate
            reaccel_normal <= (rtlim_q == 8'h00);
          end else if (rtlim_q != 8'h00 && rt_cnt_q >= rtlim_q) begin
            // [RL17] timeout raises undervoltage
            rt_q <= dif_pkg::DIF_RT_FAULT;
            {ride_active, fast_decel} <= 2'b00;
            undervoltage_fault <= 1'b1;
          end
        end
        dif_pkg::DIF_RT_FAULT: begin
          if (!power_loss && !c_rt) begin
            rt_q <= dif_pkg::DIF_RT_IDLE;
            undervoltage_fault <= 1'b0;
          end
        end
        default: rt_q <= dif_pkg::DIF_RT_IDLE;
      endcase
    end
  end
  // ==========================================================================
  // Serial loopback test: a pseudo-random stream whose echo must match.
  logic [7:0] lfsr_q, tcnt_q;
  logic [dif_pkg::LOOP_DLY-1:0] hist_q;
  logic ctst_q, err_q;
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      lfsr_q <= 8'h01;
      tcnt_q <= '0;
      hist_q <= '1;
      {ctst_q, err_q, test_busy, test_pass, test_fail} <= 5'h00;
      ser_tx <= 1'b1;
    end else begin
      ctst_q <= c_ctst;
      hist_q <= {hist_q[dif_pkg::LOOP_DLY-2:0], ser_tx};
      if (c_ctst && !ctst_q) begin
        {test_busy, test_pass, test_fail, err_q} <= 4'h8;
        tcnt_q <= '0;
      end else if (test_busy) begin
        // [RL21] send then compare the echoed bit
        lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
        ser_tx <= lfsr_q[7];
        tcnt_q <= tcnt_q + 8'h01;
        if (tcnt_q > 8'(dif_pkg::LOOP_DLY) && rx_q != hist_q[dif_pkg::LOOP_DLY - 1]) err_q <= 1'b1;
        if (tcnt_q == dif_pkg::TEST_LEN) begin
          test_busy <= 1'b0;
          ser_tx <= 1'b1;
          test_pass <= ~err_q;
          test_fail <= err_q;
        end
      end
    end
  end
  // ==========================================================================
  // Register read port
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      reg_rdata <= 16'h0000;
      for (int i = 0; i < NUM_IN; i++) begin
        if (reg_addr == dif_pkg::A_FSEL0 + 8'(i)) reg_rdata <= {8'h00, fsel_q[i]};
      end
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == dif_pkg::A_OFS0 + 8'(i)) reg_rdata <= ofs_q[i];
      end
      if (reg_addr == dif_pkg::A_CFG) reg_rdata <= {13'h0000, cfg_q};
      else if (reg_addr == dif_pkg::A_MINBB) reg_rdata <= {8'h00, minbb_q};
      else if (reg_addr == dif_pkg::A_VOLT) reg_rdata <= {7'h00, volt_q};
      else if (reg_addr == dif_pkg::A_RTLIM) reg_rdata <= {8'h00, rtlim_q};
      else if (reg_addr == dif_pkg::A_STAT) reg_rdata <= {9'h000, setting_conflict_error, undervoltage_fault,
                                                          ride_active, dc_brake, test_busy, test_pass, test_fail};
      else if (reg_addr == dif_pkg::A_BUSTGT) reg_rdata <= {2'h0, bus_target};
      else if (reg_addr == dif_pkg::A_CONT) reg_rdata <= 16'(cont_q);
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
  // ==========================================================================
  // Assertions
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_integ_reset_follow: assert property (c_irst |=> integ_reset) else $error("integral reset missed"); // [RL1]
  a_hold_yields_reset: assert property (integ_reset |-> !integ_hold) else $error("hold during reset"); // [RL2]
  a_polarity_follow: assert property (c_einv |=> err_invert) else $error("inversion missed"); // [RL4]
  a_ramp_follow: assert property (c_sfsc |=> ramp_cancel) else $error("ramp cancel missed"); // [RL3]
  a_run_exclusive: assert property (!(run_fwd && run_rev)) else $error("both directions"); // [RL5]
  a_jog_priority: assert property (jog_cmd |=> jog_run && !run_fwd && !run_rev) else $error("jog lost"); // [RL10]
  a_brake_release: assert property (run_any |=> !dc_brake) else $error("brake held on run"); // [RL10]
  a_search_conflict: assert property (a_ss1 && a_ss2 |=> setting_conflict_error) else $error("no conflict"); // [RL14]
  a_search_after_block: assert property (search_start |-> bb_q == '0 && !blk_q) else $error("early search"); // [RL15]
  a_ride_timeout: assert property (rt_q == dif_pkg::DIF_RT_RIDE && power_loss && rtlim_q != 8'h00
    && rt_cnt_q >= rtlim_q |=> undervoltage_fault && !ride_active) else $error("no timeout fault"); // [RL17]
  a_volt_range: assert property (volt_q >= vlo && volt_q <= vhi) else $error("voltage out of range"); // [RL20]
  a_test_ends: assert property ($rose(test_busy) |-> ##256 !test_busy) else $error("test overran"); // [RL21]
  c_search_run: cover property (search_start && search_from_max);
  c_ride_fault: cover property ($rose(undervoltage_fault));
  c_test_pass: cover property ($rose(test_pass));
  c_brake_on: cover property ($rose(dc_brake));
endmodule

// ==== dif_pkg.sv ====
// Constants, register map and types of the contact input function decoder.
package dif_pkg;
  // ==========================================================================
  // Timing
  localparam int    CLK_NS    = 5;
  localparam longint TENTH_NS = 100_000_000;
  localparam int    TENTH_CYC = int'(TENTH_NS / CLK_NS);
  localparam int    LOOP_DLY  = 2;
  localparam logic [7:0] TEST_LEN = 8'hFF;
  // ==========================================================================
  // Function codes
  localparam logic [7:0] FN_NONE = 8'h00;
  localparam logic [7:0] FN_IRST = 8'h30;
  localparam logic [7:0] FN_IHLD = 8'h31;
  localparam logic [7:0] FN_SFSC = 8'h34;
  localparam logic [7:0] FN_EINV = 8'h35;
  localparam logic [7:0] FN_FWD1 = 8'h40;
  localparam logic [7:0] FN_REV1 = 8'h41;
  localparam logic [7:0] FN_RUN2 = 8'h42;
  localparam logic [7:0] FN_DIR2 = 8'h43;
  localparam logic [7:0] FN_OFS1 = 8'h44;
  localparam logic [7:0] FN_OFS2 = 8'h45;
  localparam logic [7:0] FN_OFS3 = 8'h46;
  localparam logic [7:0] FN_DCB  = 8'h60;
  localparam logic [7:0] FN_SS1  = 8'h61;
  localparam logic [7:0] FN_SS2  = 8'h62;
  localparam logic [7:0] FN_RTNC = 8'h65;
  localparam logic [7:0] FN_RTNO = 8'h66;
  localparam logic [7:0] FN_CTST = 8'h67;
  // ==========================================================================
  // Register offsets
  localparam logic [7:0] A_FSEL0  = 8'h00;
  localparam logic [7:0] A_OFS0   = 8'h08;
  localparam logic [7:0] A_CFG    = 8'h0C;
  localparam logic [7:0] A_MINBB  = 8'h0D;
  localparam logic [7:0] A_VOLT   = 8'h0E;
  localparam logic [7:0] A_RTLIM  = 8'h0F;
  localparam logic [7:0] A_STAT   = 8'h10;
  localparam logic [7:0] A_BUSTGT = 8'h11;
  localparam logic [7:0] A_CONT   = 8'h12;
  // ==========================================================================
  // Fields and reset values
  localparam int CFG_NOSTART = 0;
  localparam int CFG_METHOD  = 1;
  localparam int CFG_HICLASS = 2;
  localparam logic [7:0]  FSEL_RST  = 8'h00;
  localparam logic [15:0] OFS_RST   = 16'h0000;
  localparam logic [2:0]  CFG_RST   = 3'h0;
  localparam logic [7:0]  MINBB_RST = 8'h05;
  localparam logic [7:0]  RTLIM_RST = 8'h00;
  localparam logic [8:0]  VOLT_LO   = 9'h09B;
  localparam logic [8:0]  VOLT_HI   = 9'h0FF;
  localparam logic [8:0]  VOLT_DEF  = 9'h0C8;
  localparam logic [13:0] BUS_NUM   = 14'h001B;
  localparam logic [13:0] BUS_DEN   = 14'h0014;
  // ==========================================================================
  // Ride-through states
  typedef enum logic [1:0] {
    DIF_RT_IDLE  = 2'b00,
    DIF_RT_RIDE  = 2'b01,
    DIF_RT_FAULT = 2'b10
  } dif_rt_e;
endpackage

// ==== dif_field.sv ====
// Model of the contact switches and serial wiring outside the input function decoder.
`timescale 1ns/100ps
module dif_field (
  input  wire logic [6:0] sw_set,
  input  wire logic       loop_on,
  input  wire logic       ser_tx,
  output logic      [6:0] contact_in,
  output logic            ser_rx
);
  // ==========================================================================
  // Switches
  initial contact_in = 7'h00;
  // Contacts move off edge
  // Contacts change a little after the clock edge, so the decoder must synchronise them.
  always @(sw_set) contact_in <= #2 sw_set;
  // ==========================================================================
  // Serial wiring
  // Transmit looped to receive
  // An open loop shows the inverse of the line, so an unwired port can never pass by chance.
  assign ser_rx = loop_on ? ser_tx : ~ser_tx;
endmodule

// ==== tb_top.sv ====
// Self-checking bench of the contact input function decoder.
`timescale 1ns/100ps
module tb_top;
  localparam int TC = 10;
  localparam logic [7:0] CT [2][7] = '{'{8'h30, 8'h31, 8'h34, 8'h35, 8'h40, 8'h41, 8'h00},
                                      '{8'h44, 8'h45, 8'h46, 8'h00, 8'h42, 8'h43, 8'h60}};
  logic        clk_sys = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata, rv;
  logic [6:0]  sw_set = 7'h00, contact_in, c;
  logic        motor_stopped = 1'b0, jog_cmd = 1'b0, output_block = 1'b0, power_loss = 1'b0, loop_on = 1'b1;
  logic        ser_rx, ser_tx, integ_reset, integ_hold, ramp_cancel, err_invert, run_fwd, run_rev, jog_run;
  logic        dc_brake, search_start, search_from_max, setting_conflict_error, ride_active, fast_decel;
  logic        undervoltage_fault, reaccel_normal, test_busy, test_pass, test_fail;
  logic [17:0] offset_add;
  logic [13:0] bus_target;
  logic [31:0] rs = 32'hD6D3;
  logic [15:0] o [3];
  int          errors = 0, checks = 0, n;

  // ==========================================================================
  // Device and field
  dif_top #(.TENTH_CYC(TC)) dif_top_inst (.clk_sys, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .contact_in, .motor_stopped, .jog_cmd, .output_block, .power_loss, .ser_rx, .ser_tx, .integ_reset,
    .integ_hold, .ramp_cancel, .err_invert, .run_fwd, .run_rev, .jog_run, .offset_add, .dc_brake, .search_start,
    .search_from_max, .setting_conflict_error, .ride_active, .fast_decel, .bus_target, .undervoltage_fault,
    .reaccel_normal, .test_busy, .test_pass, .test_fail);
  dif_field dif_field_inst (.sw_set, .loop_on, .ser_tx, .contact_in, .ser_rx);

  always #2.5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic pick(input int w);
    case (w)
      0: return search_start;
      1: return undervoltage_fault;
      2: return reaccel_normal;
      default: return ~test_busy;
    endcase
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic cy(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  // Pulses are caught by looking one step after every edge, so a one-cycle strobe is never missed.
  task automatic wt(input int w, output int k);
    k = 0;
    while (pick(w) !== 1'b1 && k < 600) begin
      cy(1);
      k++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e, input string nm);
    rd(a, rv);
    chk(nm, rv, e);
  endtask
  task automatic sw(input logic [6:0] v);
    @(posedge clk_sys);
    sw_set <= v;
    cy(4);
  endtask
  task automatic test_done;
    if (errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ==========================================================================
  // Watchdog
  // The whole sequence needs a little over a thousand cycles; this margin only trips on a hang.
  initial begin
    repeat (40000) @(posedge clk_sys);
    errors++;
    test_done();
  end

  // ==========================================================================
  // Sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    cy(3);
    chk("bus_target", bus_target, 14'h010E);
    rc(dif_pkg::A_MINBB, 16'h0005, "minbb");
    rc(8'h07, 16'h0000, "unmapped");
    rc(dif_pkg::A_VOLT, 16'h00C8, "volt");
    wr(dif_pkg::A_VOLT, 16'h009A);
    rc(dif_pkg::A_VOLT, 16'h00C8, "volt_low");
    wr(dif_pkg::A_VOLT, 16'h00FF);
    rc(dif_pkg::A_VOLT, 16'h00FF, "volt_top");
    cy(3);
    chk("bus_target", bus_target, 14'h0158);
    wr(dif_pkg::A_CFG, 16'h0004);
    rc(dif_pkg::A_VOLT, 16'h0190, "volt_high");
    cy(3);
    chk("bus_target", bus_target, 14'h021C);
    wr(dif_pkg::A_CFG, 16'h0000);
    for (int p = 0; p < 2; p++) begin
      for (int t = 0; t < 7; t++) wr(8'(t), 16'h0000);
      for (int t = 0; t < 7; t++) wr(8'(t), {8'h00, CT[p][t]});
      for (int k = 0; k < 3; k++) begin
        rs = xs(rs);
        o[k] = rs[15:0];
        wr(dif_pkg::A_OFS0 + 8'(k), o[k]);
      end
      motor_stopped <= p[0];
      repeat (12) begin
        rs = xs(rs);
        c = rs[6:0];
        sw(c);
        rc(dif_pkg::A_CONT, {9'h000, c}, "contacts");
        if (p == 0) begin
          chk("integ_reset", integ_reset, c[0]);
          chk("integ_hold", integ_hold, c[1] & ~c[0]);
          chk("ramp_cancel", ramp_cancel, c[2]);
          chk("err_invert", err_invert, c[3]);
          chk("run_fwd", run_fwd, c[4] & ~c[5]);
          chk("run_rev", run_rev, c[5] & ~c[4]);
        end else begin
          chk("offset_add", offset_add, (c[0] ? 32'(o[0]) : 0) + (c[1] ? 32'(o[1]) : 0) + (c[2] ? 32'(o[2]) : 0));
          chk("run_fwd", run_fwd, c[4] & c[5]);
          chk("run_rev", run_rev, c[4] & ~c[5]);
          chk("dc_brake", dc_brake, c[6] & ~c[4]);
        end
      end
    end
    sw(7'h40);
    chk("dc_brake", dc_brake, 1'b1);
    @(posedge clk_sys);
    jog_cmd <= 1'b1;
    cy(4);
    chk("dc_brake", dc_brake, 1'b0);
    sw(7'h70);
    chk("jog_run", jog_run, 1'b1);
    chk("run_fwd", run_fwd, 1'b0);
    @(posedge clk_sys);
    jog_cmd <= 1'b0;
    sw(7'h00);
    // The old codes are cleared first so only the two search inputs stay assigned.
    for (int t = 0; t < 7; t++) wr(8'(t), 16'h0000);
    wr(8'h00, 16'h0061);
    wr(8'h01, 16'h0062);
    cy(4);
    chk("conflict", setting_conflict_error, 1'b1);
    rd(dif_pkg::A_STAT, rv);
    chk("status_conflict", rv[6], 1'b1);
    wr(8'h01, 16'h0000);
    wr(dif_pkg::A_CFG, 16'h0001);
    cy(80);
    chk("conflict", setting_conflict_error, 1'b0);
    sw(7'h01);
    wt(0, n);
    chk("search_pulse", n < 20, 1'b1);
    chk("search_from_max", search_from_max, 1'b1);
    sw(7'h00);
    wr(8'h00, 16'h0062);
    output_block <= 1'b1;
    repeat (3) @(posedge clk_sys);
    output_block <= 1'b0;
    sw_set <= 7'h01;
    wt(0, n);
    chk("block_wait", n >= 45 && n < 100, 1'b1);
    chk("search_from_max", search_from_max, 1'b0);
    sw(7'h00);
    wr(dif_pkg::A_CFG, 16'h0003);
    wr(8'h00, 16'h0061);
    sw(7'h01);
    wt(0, n);
    chk("search_method", search_from_max, 1'b0);
    sw(7'h00);
    wr(8'h00, 16'h0000);
    wr(8'h06, 16'h0066);
    wr(dif_pkg::A_RTLIM, 16'h0003);
    sw(7'h40);
    @(posedge clk_sys);
    power_loss <= 1'b1;
    cy(4);
    chk("ride_active", ride_active, 1'b1);
    chk("fast_decel", fast_decel, 1'b1);
    wt(1, n);
    chk("uv_time", n >= 15 && n <= 45, 1'b1);
    @(posedge clk_sys);
    power_loss <= 1'b0;
    sw(7'h00);
    chk("undervoltage", undervoltage_fault, 1'b0);
    wr(8'h06, 16'h0065);
    wr(dif_pkg::A_RTLIM, 16'h0000);
    power_loss <= 1'b1;
    cy(4);
    chk("ride_active", ride_active, 1'b1);
    @(posedge clk_sys);
    power_loss <= 1'b0;
    wt(2, n);
    chk("reaccel", n < 6, 1'b1);
    wr(8'h06, 16'h0000);
    wr(8'h03, 16'h0067);
    sw(7'h08);
    chk("test_busy", test_busy, 1'b1);
    wt(3, n);
    chk("test_pass", {test_pass, test_fail}, 2'b10);
    sw(7'h00);
    loop_on <= 1'b0;
    sw(7'h08);
    wt(3, n);
    chk("test_fail", {test_pass, test_fail}, 2'b01);
    test_done();
  end
endmodule
